// ---- nes_flash_model.sv ----
// behavioural flash device answering data read cycles
`timescale 1ns/1ns
`default_nettype none
module nes_flash_model #(
  parameter int          SLOW_WAIT = 5,
  parameter logic [31:0] WORD_BASE = 32'h5A3C96E1
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        slow_i,
  input  wire logic        rd_req_i,
  output logic             rd_ack_o,
  output logic      [31:0] rd_data_o
);
  logic       busy_ff;
  logic [7:0] cnt_ff;
  int         wait_ff;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_ff   <= 1'b0;
      cnt_ff    <= 8'h00;
      wait_ff   <= 0;
      rd_ack_o  <= 1'b0;
      rd_data_o <= 32'h00000000;
    end else begin
      rd_ack_o  <= 1'b0;
      // bus released: never leave the last word standing
      rd_data_o <= ~rd_data_o;
      if (rd_req_i && !busy_ff) begin
        busy_ff <= 1'b1;
        wait_ff <= slow_i ? SLOW_WAIT : 0;
      end else if (busy_ff && wait_ff == 0) begin
        rd_ack_o  <= 1'b1;
        rd_data_o <= WORD_BASE ^ {4{cnt_ff}};
        cnt_ff    <= cnt_ff + 8'h01;
        busy_ff   <= 1'b0;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 1;
      end
    end
  end
endmodule : nes_flash_model
`default_nettype wire

// ---- nes_pkg.sv ----
// constants, field layouts and types for the flash check-status block
// Behaviour
// - reading the spare check-code register also runs one flash data read
// - first check bytes in 7:0 and 15:8, second ones in 23:16 and 31:24
// - program or erase to a locked area sets status bit 3, reset 0
// - ready line edge sets status bit 2 and raises an enabled interrupt
// - writing one to status bit 2 clears it, zero leaves it
// - control bit 8 picks which ready line edge is watched
// - status bit 1 mirrors the chip select pin, reads 1 after reset
// - status bit 0 mirrors the ready line: 0 busy, 1 ready, reset 1
// - two check-status registers, one per byte lane, same layout
// - bits 1:0 class main area: none, single, multiple, code area
// - bits 3:2 class the spare area with the same four codes
// - main fault: byte index in 17:7, bit position in 6:4
// - spare fault: byte index in 24:21, bit position in 20:18
// - two read-only registers show the generated main codes per lane
// - main codes update on main accesses only while control bit 5 is 0
// - spare codes update on spare accesses only while control bit 6 is 0
package nes_pkg;
  localparam logic [31:0] NES_OFS_SPARE_CODE = 32'h4E00001C;
  localparam logic [31:0] NES_OFS_STATUS     = 32'h4E000020;
  localparam logic [31:0] NES_OFS_CHK_LO     = 32'h4E000024;
  localparam logic [31:0] NES_OFS_CHK_HI     = 32'h4E000028;
  localparam logic [31:0] NES_OFS_GEN_LO     = 32'h4E00002C;
  localparam logic [31:0] NES_OFS_GEN_HI     = 32'h4E000030;
  localparam int          NES_ST_READY       = 0;
  localparam int          NES_ST_CS          = 1;
  localparam int          NES_ST_EDGE        = 2;
  localparam int          NES_ST_VIOL        = 3;
  localparam logic [31:0] NES_RST_WORD       = 32'h00000000;
  localparam logic        NES_RST_PIN_LVL    = 1'b1;
  localparam logic [15:0] NES_MAIN_PAIRS     = 16'h3FFF;
  localparam logic [15:0] NES_SPARE_PAIRS    = 16'h007F;
  typedef enum logic [1:0] {
    NES_CLS_NONE   = 2'b00,
    NES_CLS_SINGLE = 2'b01,
    NES_CLS_MULTI  = 2'b10,
    NES_CLS_AREA   = 2'b11
  } nes_cls_t;
  typedef struct packed {
    logic [6:0]  resv;
    logic [3:0]  spare_fault_byte_index;
    logic [2:0]  spare_fault_bit_pos;
    logic [10:0] primary_fault_byte_index;
    logic [2:0]  primary_fault_bit_pos;
    nes_cls_t    spare_region_fault_class;
    nes_cls_t    primary_region_fault_class;
  } nes_chk_t;
  typedef enum logic {
    NES_BUS_IDLE  = 1'b0,
    NES_BUS_FLASH = 1'b1
  } nes_bus_st_t;
endpackage : nes_pkg

// ---- nes_status_regs.sv ----
// check-code and status register block of the flash controller
`timescale 1ns/1ns
`default_nettype none
module nes_status_regs (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        ready_busy_line_i,
  input  wire logic        chip_select_pin_state_i,
  input  wire logic        ready_edge_polarity_i,
  input  wire logic        ready_edge_irq_en_i,
  output logic             ready_edge_irq_o,
  input  wire logic        lock_active_i,
  input  wire logic        protect_attempt_i,
  input  wire logic        primary_code_freeze_i,
  input  wire logic        spare_code_freeze_i,
  input  wire logic        main_access_i,
  input  wire logic [31:0] main_code_lo_i,
  input  wire logic [31:0] main_code_hi_i,
  input  wire logic [31:0] main_loaded_lo_i,
  input  wire logic [31:0] main_loaded_hi_i,
  input  wire logic        spare_access_i,
  input  wire logic [31:0] spare_code_i,
  output logic             flash_rd_req_o,
  input  wire logic        flash_rd_ack_i,
  input  wire logic [31:0] flash_rd_data_i
);
  nes_pkg::nes_bus_st_t bus_st_ff;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic                 flash_rd_req_ff;
  logic                 irq_ff;
  logic [31:0]          spare_check_code_ff;
  logic [31:0]          gen_lo_ff;
  logic [31:0]          gen_hi_ff;
  logic [31:0]          spare_gen_ff;
  logic                 ready_lvl_ff;
  logic                 cs_lvl_ff;
  logic                 ready_prev_ff;
  logic                 ready_edge_flag_ff;
  logic                 protect_violation_flag_ff;
  logic                 eval_ff;
  nes_pkg::nes_chk_t    chk_lo_ff;
  nes_pkg::nes_chk_t    chk_hi_ff;
  nes_pkg::nes_chk_t    nxt_chk_lo;
  nes_pkg::nes_chk_t    nxt_chk_hi;
  logic                 setup;
  logic                 xfer;
  logic                 wr_done;
  logic                 spare_sel;
  logic                 mapped;
  logic [31:0]          rd_word;
  logic [31:0]          status_word;
  logic                 edge_seen;
  logic                 edge_clr;
  logic                 viol_clr;
  logic                 flash_done;

  assign prdata_o         = prdata_ff;
  assign pready_o         = pready_ff;
  assign pslverr_o        = pslverr_ff;
  assign flash_rd_req_o   = flash_rd_req_ff;
  assign ready_edge_irq_o = irq_ff;

  assign setup      = psel_i && !penable_i;
  assign xfer       = psel_i && penable_i && pready_ff;
  assign wr_done    = xfer && pwrite_i && !pslverr_ff;
  assign spare_sel  = (paddr_i == nes_pkg::NES_OFS_SPARE_CODE);
  assign flash_done = (bus_st_ff == nes_pkg::NES_BUS_FLASH) && flash_rd_ack_i;

  assign status_word = {28'h0000000,
                        protect_violation_flag_ff,
                        ready_edge_flag_ff,
                        cs_lvl_ff,
                        ready_lvl_ff};

  // plain if chain: offsets are sparse and few
  always_comb begin
    rd_word = 32'h00000000;
    mapped  = 1'b1;
    if (spare_sel) begin
      rd_word = spare_check_code_ff;
    end else if (paddr_i == nes_pkg::NES_OFS_STATUS) begin
      rd_word = status_word;
    end else if (paddr_i == nes_pkg::NES_OFS_CHK_LO) begin
      rd_word = chk_lo_ff;
    end else if (paddr_i == nes_pkg::NES_OFS_CHK_HI) begin
      rd_word = chk_hi_ff;
    end else if (paddr_i == nes_pkg::NES_OFS_GEN_LO) begin
      rd_word = gen_lo_ff;
    end else if (paddr_i == nes_pkg::NES_OFS_GEN_HI) begin
      rd_word = gen_hi_ff;
    end else begin
      mapped = 1'b0;
    end
  end

  // apb slave; a spare code read stalls until the flash returns a word
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_st_ff       <= nes_pkg::NES_BUS_IDLE;
      prdata_ff       <= nes_pkg::NES_RST_WORD;
      pready_ff       <= 1'b0;
      pslverr_ff      <= 1'b0;
      flash_rd_req_ff <= 1'b0;
    end else begin
      flash_rd_req_ff <= 1'b0;
      case (bus_st_ff)
        nes_pkg::NES_BUS_IDLE: begin
          if (xfer) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= nes_pkg::NES_RST_WORD;
          end else if (setup && spare_sel && !pwrite_i) begin
            flash_rd_req_ff <= 1'b1;
            bus_st_ff       <= nes_pkg::NES_BUS_FLASH;
          end else if (setup) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !mapped;
            prdata_ff  <= (pwrite_i || !mapped) ? 32'h00000000 : rd_word;
          end
        end
        nes_pkg::NES_BUS_FLASH: begin
          if (flash_rd_ack_i) begin
            pready_ff <= 1'b1;
            prdata_ff <= flash_rd_data_i;
            bus_st_ff <= nes_pkg::NES_BUS_IDLE;
          end
        end
        default: begin
          bus_st_ff <= nes_pkg::NES_BUS_IDLE;
        end
      endcase
    end
  end

  // spare check code: loaded by software or by the flash read it triggers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      spare_check_code_ff <= nes_pkg::NES_RST_WORD;
    end else if (flash_done) begin
      spare_check_code_ff <= flash_rd_data_i;
    end else if (wr_done && spare_sel) begin
      spare_check_code_ff <= pwdata_i;
    end
  end

  // generated codes, frozen by the lock bits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gen_lo_ff    <= nes_pkg::NES_RST_WORD;
      gen_hi_ff    <= nes_pkg::NES_RST_WORD;
      spare_gen_ff <= nes_pkg::NES_RST_WORD;
    end else begin
      if (main_access_i && !primary_code_freeze_i) begin
        gen_lo_ff <= main_code_lo_i;
        gen_hi_ff <= main_code_hi_i;
      end
      if (spare_access_i && !spare_code_freeze_i) begin
        spare_gen_ff <= spare_code_i;
      end
    end
  end

  // pins are sampled once; reset shows both lines idle high
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ready_lvl_ff  <= nes_pkg::NES_RST_PIN_LVL;
      cs_lvl_ff     <= nes_pkg::NES_RST_PIN_LVL;
      ready_prev_ff <= nes_pkg::NES_RST_PIN_LVL;
    end else begin
      ready_lvl_ff  <= ready_busy_line_i;
      cs_lvl_ff     <= chip_select_pin_state_i;
      ready_prev_ff <= ready_lvl_ff;
    end
  end

  // polarity 0 watches busy-to-ready, 1 the opposite edge
  assign edge_seen = ready_edge_polarity_i ?
                     (ready_prev_ff && !ready_lvl_ff) :
                     (!ready_prev_ff && ready_lvl_ff);
  assign edge_clr  = wr_done && (paddr_i == nes_pkg::NES_OFS_STATUS) &&
                     pwdata_i[nes_pkg::NES_ST_EDGE];
  assign viol_clr  = wr_done && (paddr_i == nes_pkg::NES_OFS_STATUS) &&
                     pwdata_i[nes_pkg::NES_ST_VIOL];

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ready_edge_flag_ff <= 1'b0;
    end else if (edge_seen) begin
      ready_edge_flag_ff <= 1'b1;
    end else if (edge_clr) begin
      ready_edge_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      protect_violation_flag_ff <= 1'b0;
    end else if (protect_attempt_i && lock_active_i) begin
      protect_violation_flag_ff <= 1'b1;
    end else if (viol_clr) begin
      protect_violation_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= ready_edge_flag_ff && ready_edge_irq_en_i;
    end
  end

  // syndrome: paired bits that disagree mark one bad data bit
  function automatic logic [17:0] nes_syn(input logic [31:0] d,
                                          input logic [15:0] pm);
    logic [15:0] od;
    logic [15:0] ev;
    logic [1:0]  c;
    od = 16'h0000;
    ev = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      od[k] = d[2*k+1];
      ev[k] = d[2*k];
    end
    if (d == 32'h00000000) begin
      c = nes_pkg::NES_CLS_NONE;
    end else if (((od ^ ev) & pm) == pm) begin
      c = nes_pkg::NES_CLS_SINGLE;
    end else if ($countones(d) == 1) begin
      c = nes_pkg::NES_CLS_AREA;
    end else begin
      c = nes_pkg::NES_CLS_MULTI;
    end
    if (c != nes_pkg::NES_CLS_SINGLE) begin
      od = 16'h0000;
    end
    return {od & pm, c};
  endfunction : nes_syn

  function automatic nes_pkg::nes_chk_t nes_fold(input logic [17:0] m,
                                                input logic [17:0] s);
    nes_pkg::nes_chk_t r;
    r = '0;
    r.primary_region_fault_class = nes_pkg::nes_cls_t'(m[1:0]);
    r.primary_fault_bit_pos      = m[4:2];
    r.primary_fault_byte_index   = m[15:5];
    r.spare_region_fault_class   = nes_pkg::nes_cls_t'(s[1:0]);
    r.spare_fault_bit_pos        = s[4:2];
    r.spare_fault_byte_index     = s[8:5];
    return r;
  endfunction : nes_fold

  // one status word per byte lane
  always_comb begin
    nxt_chk_lo = nes_fold(
      nes_syn(gen_lo_ff ^ main_loaded_lo_i, nes_pkg::NES_MAIN_PAIRS),
      nes_syn({16'h0000,
               spare_gen_ff[15:0] ^ {spare_check_code_ff[23:16],
                                     spare_check_code_ff[7:0]}},
              nes_pkg::NES_SPARE_PAIRS));
    nxt_chk_hi = nes_fold(
      nes_syn(gen_hi_ff ^ main_loaded_hi_i, nes_pkg::NES_MAIN_PAIRS),
      nes_syn({16'h0000,
               spare_gen_ff[31:16] ^ {spare_check_code_ff[31:24],
                                      spare_check_code_ff[15:8]}},
              nes_pkg::NES_SPARE_PAIRS));
  end

  // a generated or spare check code change schedules a fresh comparison one cycle later; main_loaded_lo_i and main_loaded_hi_i changes do not
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      eval_ff <= 1'b0;
    end else begin
      eval_ff <= (main_access_i && !primary_code_freeze_i) ||
                 (spare_access_i && !spare_code_freeze_i) ||
                 flash_done || (wr_done && spare_sel);
    end
  end

  // hardware result wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      chk_lo_ff <= nes_pkg::NES_RST_WORD;
      chk_hi_ff <= nes_pkg::NES_RST_WORD;
    end else if (eval_ff) begin
      chk_lo_ff <= nxt_chk_lo;
      chk_hi_ff <= nxt_chk_hi;
    end else if (wr_done) begin
      if (paddr_i == nes_pkg::NES_OFS_CHK_LO) begin
        chk_lo_ff <= pwdata_i;
      end else if (paddr_i == nes_pkg::NES_OFS_CHK_HI) begin
        chk_hi_ff <= pwdata_i;
      end
    end
  end

  default clocking nes_cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  edge_rise_set_a: assert property (
    !ready_edge_polarity_i && !ready_prev_ff && ready_lvl_ff
    |=> ready_edge_flag_ff ##1 (irq_ff == ready_edge_irq_en_i))
    else $error("rising ready edge did not set the edge flag");
  edge_fall_set_a: assert property (
    ready_edge_polarity_i && ready_prev_ff && !ready_lvl_ff
    |=> ready_edge_flag_ff)
    else $error("falling ready edge did not set the edge flag");
  edge_clear_a: assert property (
    edge_clr && !edge_seen |=> !ready_edge_flag_ff)
    else $error("write one did not clear the edge flag");
  edge_keep_a: assert property (
    ready_edge_flag_ff && !edge_clr |=> ready_edge_flag_ff)
    else $error("edge flag dropped without a write of one");
  viol_set_a: assert property (
    protect_attempt_i && lock_active_i
    |=> protect_violation_flag_ff && status_word[3])
    else $error("locked access did not set the violation flag");
  flash_read_a: assert property (
    setup && spare_sel && !pwrite_i && bus_st_ff == nes_pkg::NES_BUS_IDLE
    |=> flash_rd_req_o ##1 !flash_rd_req_o)
    else $error("spare code read did not pulse a flash read");
  flash_data_a: assert property (
    flash_done |=> pready_o && prdata_o == $past(flash_rd_data_i)
                   && spare_check_code_ff == $past(flash_rd_data_i))
    else $error("flash word not returned and stored");
  main_freeze_a: assert property (
    primary_code_freeze_i |=> $stable(gen_lo_ff) && $stable(gen_hi_ff))
    else $error("main codes moved while frozen");
  spare_freeze_a: assert property (
    spare_code_freeze_i |=> $stable(spare_gen_ff))
    else $error("spare codes moved while frozen");
  pin_mirror_a: assert property (
    ##2 (status_word[0] == $past(ready_busy_line_i, 1)) &&
    (status_word[1] == $past(chip_select_pin_state_i, 1)))
    else $error("status pin bits do not follow the pins");
  main_clean_a: assert property (
    eval_ff && gen_lo_ff == main_loaded_lo_i
    |=> chk_lo_ff.primary_region_fault_class == nes_pkg::NES_CLS_NONE)
    else $error("matching codes not classed as clean");

  flash_read_c: cover property (flash_rd_req_o ##[1:20] flash_done);
  edge_irq_c: cover property (ready_edge_flag_ff ##1 irq_ff);
  single_err_c: cover property (
    chk_lo_ff.primary_region_fault_class == nes_pkg::NES_CLS_SINGLE);
endmodule : nes_status_regs
`default_nettype wire

// ---- nes_status_regs_tb_top.sv ----
// self-checking bench for the flash check-status register block
`timescale 1ns/1ns
`default_nettype none
module nes_status_regs_tb_top;
  localparam logic [31:0] WORD_BASE = 32'h5A3C96E1;
  logic        clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
  logic        pslverr_o, ready_busy_line_i, chip_select_pin_state_i;
  logic        ready_edge_polarity_i, ready_edge_irq_en_i, ready_edge_irq_o;
  logic        lock_active_i, protect_attempt_i, primary_code_freeze_i;
  logic        spare_code_freeze_i, main_access_i, spare_access_i, se, slow;
  logic [31:0] main_code_lo_i, main_code_hi_i, spare_code_i, flash_rd_data_i;
  logic [31:0] main_loaded_lo_i, main_loaded_hi_i, gl;
  logic        flash_rd_req_o, flash_rd_ack_i;
  logic [31:0] dif [4];
  logic [31:0] exv [4];
  int          err_count, comparisons, reqs;

  nes_status_regs dut (.*);
  nes_flash_model #(.WORD_BASE(WORD_BASE)) flash (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .slow_i(slow), .rd_req_i(flash_rd_req_o), .rd_ack_o(flash_rd_ack_i),
    .rd_data_o(flash_rd_data_i));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (flash_rd_req_o === 1'b1) reqs <= reqs + 1;

  task automatic results();
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // whole-word transfers only, no byte lanes on this bus
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // no wait limit here: only the watchdog ends a stalled transfer
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    se = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [31:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rd);
  endtask : rchk

  task automatic pulse(input int which);
    if (which == 0) main_access_i <= 1'b1;
    else if (which == 1) spare_access_i <= 1'b1;
    else protect_attempt_i <= 1'b1;
    @(posedge clk_i);
    main_access_i     <= 1'b0;
    spare_access_i    <= 1'b0;
    protect_attempt_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse

  initial begin
    #(30000 * 8);
    err_count++;
    results();
  end

  initial begin
    {clk_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {ready_edge_polarity_i, ready_edge_irq_en_i, lock_active_i} = '0;
    {protect_attempt_i, primary_code_freeze_i, spare_code_freeze_i} = '0;
    {main_access_i, spare_access_i, spare_code_i, slow, reqs} = '0;
    {main_code_lo_i, main_code_hi_i, main_loaded_lo_i, main_loaded_hi_i} = '0;
    {err_count, comparisons} = '0;
    sys_rst_i = 1'b1;
    ready_busy_line_i = 1'b1;
    chip_select_pin_state_i = 1'b1;
    // one-error diff: each of the 14 masked pairs differs once, odd bits give location
    dif[0] = 32'h00000000;
    dif[1] = 32'h09A66A9A;
    dif[2] = 32'h00000200;
    dif[3] = 32'h00000003;
    exv[0] = 32'h00000000;
    exv[1] = {14'h0000, 14'h2D7B, 4'h1};
    exv[2] = 32'h00000003;
    exv[3] = 32'h00000002;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rchk("status_rst", dut_ofs(1), 32'h00000003);
    rchk("chk_lo_rst", dut_ofs(2), 32'h00000000);
    rchk("chk_hi_rst", dut_ofs(3), 32'h00000000);
    rchk("gen_hi_rst", dut_ofs(5), 32'h00000000);
    apb(1'b0, 32'h4E000034, 32'h00000000);
    chk("unmapped_err", 32'h00000001, {31'h0, se});
    apb(1'b1, dut_ofs(4), 32'hFFFFFFFF);
    rchk("gen_lo_ro", dut_ofs(4), 32'h00000000);
    for (int k = 0; k < 4; k++) begin
      gl = 32'h0C3A5196 ^ k;
      main_code_lo_i   <= gl;
      main_code_hi_i   <= ~gl;
      main_loaded_lo_i <= gl ^ dif[k];
      main_loaded_hi_i <= ~gl ^ dif[k];
      pulse(0);
      rchk("gen_lo", dut_ofs(4), gl);
      rchk("gen_hi", dut_ofs(5), ~gl);
      rchk("chk_lo", dut_ofs(2), exv[k]);
      rchk("chk_hi", dut_ofs(3), exv[k]);
    end
    primary_code_freeze_i <= 1'b1;
    main_code_lo_i <= 32'h12345678;
    pulse(0);
    rchk("gen_frozen", dut_ofs(4), gl);
    primary_code_freeze_i <= 1'b0;
    spare_code_freeze_i <= 1'b1;
    spare_code_i <= 32'h00000001;
    pulse(1);
    rchk("spare_frozen", dut_ofs(2), exv[3]);
    spare_code_freeze_i <= 1'b0;
    pulse(1);
    rchk("spare_cls_lo", dut_ofs(2), 32'h0000000E);
    rchk("spare_cls_hi", dut_ofs(3), 32'h00000002);
    ready_busy_line_i <= 1'b0;
    chip_select_pin_state_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk("pins_low", dut_ofs(1), 32'h00000000);
    ready_busy_line_i <= 1'b1;
    ready_edge_irq_en_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk("edge_set", dut_ofs(1), 32'h00000005);
    chk("irq_set", 32'h00000001, {31'h0, ready_edge_irq_o});
    apb(1'b1, dut_ofs(1), 32'h00000000);
    rchk("edge_keep", dut_ofs(1), 32'h00000005);
    apb(1'b1, dut_ofs(1), 32'h00000004);
    rchk("edge_clr", dut_ofs(1), 32'h00000001);
    chk("irq_clr", 32'h00000000, {31'h0, ready_edge_irq_o});
    ready_edge_polarity_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    ready_busy_line_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk("edge_fall", dut_ofs(1), 32'h00000004);
    apb(1'b1, dut_ofs(1), 32'h00000004);
    ready_busy_line_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk("rise_ignored", dut_ofs(1), 32'h00000001);
    pulse(2);
    rchk("viol_unlocked", dut_ofs(1), 32'h00000001);
    lock_active_i <= 1'b1;
    pulse(2);
    rchk("viol_set", dut_ofs(1), 32'h00000009);
    apb(1'b1, dut_ofs(1), 32'h00000008);
    rchk("viol_clr", dut_ofs(1), 32'h00000001);
    chk("no_flash_rd", 32'h00000000, reqs);
    rchk("spare_fast", dut_ofs(0), WORD_BASE);
    slow <= 1'b1;
    rchk("spare_slow", dut_ofs(0), WORD_BASE ^ 32'h01010101);
    chk("flash_rds", 32'h00000002, reqs);
    // lane 0 first byte matches the generated spare code, lane 0 spare becomes clean, lane 1 spare bytes now zero so it becomes clean too
    apb(1'b1, dut_ofs(0), 32'h00000001);
    rchk("spare_wr_lo", dut_ofs(2), 32'h00000002);
    rchk("spare_wr_hi", dut_ofs(3), 32'h00000002);
    chk("wr_no_flash", 32'h00000002, reqs);
    results();
  end

  function automatic logic [31:0] dut_ofs(input int i);
    return 32'h4E00001C + 32'h00000004 * i;
  endfunction : dut_ofs
endmodule : nes_status_regs_tb_top
`default_nettype wire
